// ### logic/exec_pkg.sv
// Purpose: constants for the four-instruction execution block
// Assumes: 8-bit data path, 10-bit program counter
// Notes: operation codes are local to this block's command port
package exec_pkg;
	localparam int          DATA_W     = 8;
	localparam int          PC_W       = 10;
	localparam int          AUX_IDX_W  = 4;
	localparam int          AUX_DEPTH  = 16;
	localparam int          STACK_DEPTH = 8;
	localparam int          SP_W       = 3;
	localparam int          CALL_CYCLES = 2;
	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [9:0]  PC_RST     = 10'h000;
	localparam logic [7:0]  AUX_RST    = 8'h00;
	localparam logic [2:0]  SP_RST     = 3'h0;
	localparam logic [9:0]  PC_ONE     = 10'h001;
	localparam logic [2:0]  SP_ONE     = 3'h1;
	localparam logic [2:0]  OP_NONE    = 3'h0;
	localparam logic [2:0]  OP_OR_IMM  = 3'h1;
	localparam logic [2:0]  OP_AUX_RD  = 3'h2;
	localparam logic [2:0]  OP_AUX_WR  = 3'h3;
	localparam logic [2:0]  OP_CALL    = 3'h4;
endpackage : exec_pkg

// ### logic/or_imm_sfr_move_call_exec.sv
// Purpose: executes or-immediate, aux page moves and long call
// Assumes: op_valid pulses from core logic on core_clk; op ignored
//          while a call is in its second cycle (busy high)
// Notes: stack overflow wraps the pointer silently
// Behaviour
// - or-immediate ors 8-bit operand into accumulator, sets zero, one cycle
// - aux read copies indexed aux register into accumulator, flags untouched
// - aux write loads indexed aux register from accumulator, flags untouched
// - long call pushes next address then loads 10-bit target, two cycles
// - call stores return at current level, pointer plus one, flags kept
`timescale 1ns/1ns
module or_imm_sfr_move_call_exec
(
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        nrst,
	// instruction command
	input  wire logic                        op_valid,
	input  wire logic [2:0]                  op_code,
	input  wire logic [exec_pkg::DATA_W-1:0] imm_data,
	input  wire logic [exec_pkg::AUX_IDX_W-1:0] aux_idx,
	input  wire logic [exec_pkg::PC_W-1:0]   call_target,
	// core state
	output logic [exec_pkg::DATA_W-1:0]      accumulator,
	output logic                             zero_flag,
	output logic [exec_pkg::PC_W-1:0]        pc,
	output logic [exec_pkg::SP_W-1:0]        stack_ptr,
	output logic [exec_pkg::PC_W-1:0]        stack_top,
	output logic                             busy,
	// aux page view
	output logic [exec_pkg::DATA_W*exec_pkg::AUX_DEPTH-1:0] aux_page
);
	typedef enum logic {ST_RUN, ST_CALL2} exec_state_e;

	// decode strobes, take plus at most one of do_or, do_rd, do_wr, do_call per edge
	logic                             take;
	logic                             do_or;
	logic                             do_rd;
	logic                             do_wr;
	logic                             do_call;

	// sequencer and program counter
	exec_state_e                      st_r;
	exec_state_e                      st_nxt;
	logic                             busy_r;
	logic                             busy_nxt;
	logic [exec_pkg::PC_W-1:0]        pc_r;
	logic [exec_pkg::PC_W-1:0]        pc_nxt;
	logic [exec_pkg::PC_W-1:0]        tgt_r;
	logic [exec_pkg::PC_W-1:0]        tgt_nxt;

	// accumulator and zero flag
	logic [exec_pkg::DATA_W-1:0]      acc_r;
	logic [exec_pkg::DATA_W-1:0]      acc_nxt;
	logic                             z_r;
	logic                             z_nxt;
	logic [exec_pkg::DATA_W-1:0]      or_res;

	// aux page
	logic [exec_pkg::DATA_W-1:0]      aux_r [exec_pkg::AUX_DEPTH];
	logic [exec_pkg::DATA_W-1:0]      aux_nxt [exec_pkg::AUX_DEPTH];

	// return stack
	logic [exec_pkg::SP_W-1:0]        sp_r;
	logic [exec_pkg::SP_W-1:0]        sp_nxt;
	logic [exec_pkg::PC_W-1:0]        stk_r [exec_pkg::STACK_DEPTH];
	logic [exec_pkg::PC_W-1:0]        stk_nxt [exec_pkg::STACK_DEPTH];
	logic [exec_pkg::PC_W-1:0]        top_r;
	logic [exec_pkg::PC_W-1:0]        top_nxt;

	// an op arriving while a call finishes is dropped, not queued:
	// the core never issues one there, so no holding slot is spent
	always_comb
	begin
		take    = op_valid && (st_r == ST_RUN);
		do_or   = 1'b0;
		do_rd   = 1'b0;
		do_wr   = 1'b0;
		do_call = 1'b0;
		if (take)
		begin
			case (op_code)
				exec_pkg::OP_OR_IMM:
					do_or = 1'b1;
				exec_pkg::OP_AUX_RD:
					do_rd = 1'b1;
				exec_pkg::OP_AUX_WR:
					do_wr = 1'b1;
				exec_pkg::OP_CALL:
					do_call = 1'b1;
				default:
				begin
					// no-op and spare codes only step the pc
				end
			endcase
		end
	end

	// sequencer: a call spends its second cycle loading the target
	always_comb
	begin
		st_nxt  = st_r;
		pc_nxt  = pc_r;
		tgt_nxt = tgt_r;
		case (st_r)
			ST_RUN:
			begin
				if (do_call)
				begin
					// pc holds so the push sees this op's address
					tgt_nxt = call_target;
					st_nxt  = ST_CALL2;
				end
				else if (take)
				begin
					pc_nxt = pc_r + exec_pkg::PC_ONE;
				end
			end
			ST_CALL2:
			begin
				pc_nxt = tgt_r;
				st_nxt = ST_RUN;
			end
			default:
			begin
				st_nxt = ST_RUN;
			end
		endcase
		// registered so the port comes straight off a flop
		busy_nxt = (st_nxt == ST_CALL2);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r   <= ST_RUN;
			busy_r <= 1'b0;
			pc_r   <= exec_pkg::PC_RST;
			tgt_r  <= exec_pkg::PC_RST;
		end
		else
		begin
			st_r   <= st_nxt;
			busy_r <= busy_nxt;
			pc_r   <= pc_nxt;
			tgt_r  <= tgt_nxt;
		end
	end

	// only or-immediate ever touches the flag
	always_comb
	begin
		acc_nxt = acc_r;
		z_nxt   = z_r;
		or_res  = acc_r | imm_data;
		if (do_or)
		begin
			acc_nxt = or_res;
			z_nxt   = (or_res == '0);
		end
		else if (do_rd)
		begin
			// flag left alone even when the copied value is zero
			acc_nxt = aux_r[aux_idx];
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			acc_r <= exec_pkg::ACC_RST;
			z_r   <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			z_r   <= z_nxt;
		end
	end

	// aux write; the read side is the accumulator mux above
	always_comb
	begin
		aux_nxt = aux_r;
		if (do_wr)
		begin
			aux_nxt[aux_idx] = acc_r;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < exec_pkg::AUX_DEPTH; gi++)
		begin : g_aux
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					aux_r[gi] <= exec_pkg::AUX_RST;
				else
					aux_r[gi] <= aux_nxt[gi];
			end
			assign aux_page[gi*exec_pkg::DATA_W +: exec_pkg::DATA_W]
				= aux_r[gi];
		end
	endgenerate

	// overflow past the last entry wraps the pointer and overwrites
	// the oldest return: a fixed-depth stack has nowhere else to go
	always_comb
	begin
		sp_nxt  = sp_r;
		stk_nxt = stk_r;
		if (do_call)
		begin
			// return address is the entry after the call itself
			stk_nxt[sp_r] = pc_r + exec_pkg::PC_ONE;
			sp_nxt        = sp_r + exec_pkg::SP_ONE;
		end
		// newest entry sits just below the pointer
		top_nxt = stk_nxt[sp_nxt - exec_pkg::SP_ONE];
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sp_r  <= exec_pkg::SP_RST;
			top_r <= exec_pkg::PC_RST;
		end
		else
		begin
			sp_r  <= sp_nxt;
			top_r <= top_nxt;
		end
	end

	generate
		for (gi = 0; gi < exec_pkg::STACK_DEPTH; gi++)
		begin : g_stk
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					stk_r[gi] <= exec_pkg::PC_RST;
				else
					stk_r[gi] <= stk_nxt[gi];
			end
		end
	endgenerate

	// every port below comes straight off a register
	assign accumulator = acc_r;
	assign zero_flag   = z_r;
	assign pc          = pc_r;
	assign stack_ptr   = sp_r;
	assign stack_top   = top_r;
	assign busy        = busy_r;
endmodule : or_imm_sfr_move_call_exec

// ### tb/exec_checker.sv
// Purpose: port checks of the execution block
// Assumes: op taken on op_valid high, busy low
// Notes: depth 8 stack wraps; AST_SP checks the 3-bit pointer wrap, the overwritten entry is not checked
`timescale 1ns/1ns
module exec_checker
(
	// clock, reset, command
	input wire logic         core_clk,
	input wire logic         nrst,
	input wire logic         op_valid,
	input wire logic [2:0]   op_code,
	input wire logic [7:0]   imm_data,
	input wire logic [3:0]   aux_idx,
	input wire logic [9:0]   call_target,
	// core state
	input wire logic [7:0]   accumulator,
	input wire logic         zero_flag,
	input wire logic [9:0]   pc,
	input wire logic [2:0]   stack_ptr,
	input wire logic [9:0]   stack_top,
	input wire logic         busy,
	input wire logic [127:0] aux_page
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// one-hot of taken op, codes 5-7 fall off the top
	wire [4:0] k = (op_valid && !busy) ? 5'h01 << op_code : 5'h00;
	AST_OR: assert property (k[1] |=>
		accumulator == ($past(accumulator) | $past(imm_data))) else $error("or");
	AST_ZERO: assert property (k[1] |=>
		zero_flag == (accumulator == 8'h00)) else $error("zero");
	AST_RD: assert property (k[2] |=> $stable(zero_flag) &&
		accumulator == $past(aux_page[aux_idx*8+:8])) else $error("rd");
	AST_WR: assert property (k[3] |=> $stable(zero_flag) &&
		aux_page[{$past(aux_idx), 3'h0}+:8] == $past(accumulator)) else $error("wr");
	AST_CALL: assert property (k[4] |=> busy &&
		stack_top == $past(pc) + 10'h001 ##1 pc == $past(call_target, 2))
		else $error("call");
	AST_SP: assert property (k[4] |=> $stable(zero_flag) &&
		stack_ptr == $past(stack_ptr) + 3'h1) else $error("sp");
	AST_REFUSE: assert property (busy && op_valid |=> !busy &&
		$stable(accumulator) && $stable(stack_ptr)) else $error("refuse");
	cover property (k[1] ##1 zero_flag);
	cover property (k[4]);
	cover property (k[3] ##4 k[2]);
	cover property (busy && op_valid);
endmodule : exec_checker
bind or_imm_sfr_move_call_exec exec_checker chk_u (
	.core_clk    (core_clk),
	.nrst        (nrst),
	.op_valid    (op_valid),
	.op_code     (op_code),
	.imm_data    (imm_data),
	.aux_idx     (aux_idx),
	.call_target (call_target),
	.accumulator (accumulator),
	.zero_flag   (zero_flag),
	.pc          (pc),
	.stack_ptr   (stack_ptr),
	.stack_top   (stack_top),
	.busy        (busy),
	.aux_page    (aux_page)
);

// ### tb/or_imm_sfr_move_call_exec_tb.sv
// Purpose: random and corner ops against a bench model
// Assumes: one op then three idle cycles
// Notes: one call holds op_valid into its busy cycle to test refusal
`timescale 1ns/1ns
module or_imm_sfr_move_call_exec_tb;
	logic         core_clk = 0, nrst = 0, op_valid = 0, zero_flag, busy, z;
	logic [2:0]   op_code = 0, stack_ptr, s;
	logic [7:0]   imm_data = 0, accumulator, a;
	logic [3:0]   aux_idx = 0;
	logic [9:0]   call_target = 0, pc, stack_top, p, r;
	logic [127:0] aux_page, g;
	int           err_count = 0, check_count = 0, seed = 32'h0f87_17da, i;
	logic [31:0]  w;
	or_imm_sfr_move_call_exec dut_u (.core_clk(core_clk), .nrst(nrst),
		.op_valid(op_valid), .op_code(op_code), .imm_data(imm_data),
		.aux_idx(aux_idx), .call_target(call_target), .busy(busy),
		.accumulator(accumulator), .zero_flag(zero_flag), .pc(pc),
		.stack_ptr(stack_ptr), .stack_top(stack_top), .aux_page(aux_page));
	task automatic cmp(input string n, input logic [127:0] e, v);
		check_count++;
		if (e !== v)
		begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, v);
		end
	endtask : cmp
	task automatic end_of_test;
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic run(input logic [2:0] o, input logic [7:0] d,
		input logic [3:0] x, input logic [9:0] t, input bit h);
		@(posedge core_clk);
		{op_valid, op_code, imm_data, aux_idx, call_target} <= {1'b1, o, d, x, t};
		@(posedge core_clk);
		// h keeps an or-immediate up into a call's busy cycle
		{op_valid, op_code} <= {h, 3'h1};
		@(posedge core_clk);
		op_valid <= 1'b0;
		@(posedge core_clk);
		r = p + 10'h001;
		if (o == 3'h1) a = a | d;
		if (o == 3'h1) z = (a == 8'h00);
		if (o == 3'h2) a = g[x*8+:8];
		if (o == 3'h3) g[x*8+:8] = a;
		if (o == 3'h4) s = s + 3'h1;
		p = (o == 3'h4) ? t : r;
		#1;
		cmp("acc", a, accumulator);
		cmp("zero", z, zero_flag);
		cmp("aux", g, aux_page);
		cmp("pc", p, pc);
		cmp("busy", 1'b0, busy);
		cmp("sp", s, stack_ptr);
		if (o == 3'h4) cmp("top", r, stack_top);
	endtask : run
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end
	initial
	begin
		{a, z, p, s, g} = '0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		run(3'h1, 8'h00, 4'hf, 10'h000, 1'b0);
		run(3'h3, 8'h00, 4'hf, 10'h000, 1'b0);
		run(3'h4, 8'h00, 4'h0, 10'h3ff, 1'b0);
		run(3'h1, 8'h5a, 4'h0, 10'h000, 1'b0);
		run(3'h2, 8'h00, 4'hf, 10'h000, 1'b0);
		run(3'h4, 8'h81, 4'h0, 10'h155, 1'b1);
		for (i = 0; i < 300; i++)
		begin
			w = $random(seed);
			run(w[2:0], w[10:3], w[14:11], w[24:15], 1'b0);
		end
		end_of_test();
	end
endmodule : or_imm_sfr_move_call_exec_tb
